// ==== verilog/pdma_pkg.sv ====
`default_nettype none
package pdma_pkg;

  // Register byte offsets within the peripheral window
  localparam logic [11:0] PDMA_OFF_RX_CUR_PTR = 12'h100;
  localparam logic [11:0] PDMA_OFF_RX_CUR_CNT = 12'h104;
  localparam logic [11:0] PDMA_OFF_TX_CUR_PTR = 12'h108;
  localparam logic [11:0] PDMA_OFF_TX_CUR_CNT = 12'h10C;
  localparam logic [11:0] PDMA_OFF_RX_NXT_PTR = 12'h110;
  localparam logic [11:0] PDMA_OFF_RX_NXT_CNT = 12'h114;
  localparam logic [11:0] PDMA_OFF_TX_NXT_PTR = 12'h118;
  localparam logic [11:0] PDMA_OFF_TX_NXT_CNT = 12'h11C;
  localparam logic [11:0] PDMA_OFF_CONTROL = 12'h120;
  localparam logic [11:0] PDMA_OFF_STATUS = 12'h124;

  // Control and status field positions
  localparam int PDMA_CTL_RX_EN = 0;
  localparam int PDMA_CTL_RX_DIS = 1;
  localparam int PDMA_CTL_TX_EN = 8;
  localparam int PDMA_CTL_TX_DIS = 9;
  localparam int PDMA_STS_RX = 0;
  localparam int PDMA_STS_TX = 8;

  // Reset values
  localparam logic [31:0] PDMA_PTR_RESET = 32'h0000_0000;
  localparam logic [15:0] PDMA_CNT_RESET = 16'h0000;

  // Element size as given by the serving peripheral
  typedef enum logic [1:0] {
    PDMA_SZ_BYTE = 2'b00,
    PDMA_SZ_HALF = 2'b01,
    PDMA_SZ_WORD = 2'b10
  } pdma_size_t;

  typedef enum logic [1:0] {
    PDMA_ST_IDLE = 2'b00,
    PDMA_ST_RX_MEM = 2'b01,
    PDMA_ST_TX_MEM = 2'b10,
    PDMA_ST_TX_HOLD = 2'b11
  } pdma_state_t;

endpackage
`default_nettype wire

// ==== verilog/pdma_channel.sv ====
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pdma_channel
  import pdma_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic half_duplex,
  input wire logic [1:0] elem_size,
  input wire logic rx_ready,
  input wire logic tx_ready,
  input wire logic [31:0] receive_holding_reg,
  output logic rx_holding_read,
  output logic [31:0] transmit_holding_reg,
  output logic tx_holding_write,
  output logic mem_req,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output logic [1:0] mem_size,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic rx_end_flag,
  output logic rx_buffer_full_flag,
  output logic tx_end_flag,
  output logic tx_buffer_empty_flag
);

  function automatic logic [31:0] elem_incr(input logic [1:0] sz);
    unique case (sz)
      PDMA_SZ_HALF: elem_incr = 32'h0000_0002;
      PDMA_SZ_WORD: elem_incr = 32'h0000_0004;
      default: elem_incr = 32'h0000_0001;
    endcase
  endfunction

  // Bank 0 holds receive (or the shared half-duplex set), bank 1 transmit
  function automatic logic bank_of(input logic is_tx, input logic hd);
    bank_of = is_tx & ~hd;
  endfunction

  logic [31:0] cur_ptr_r [2];
  logic [15:0] cur_cnt_r [2];
  logic [31:0] nxt_ptr_r [2];
  logic [15:0] nxt_cnt_r [2];
  logic rx_en_r;
  logic tx_en_r;
  logic rx_pend_r;
  logic tx_pend_r;
  logic [31:0] hold_r;
  pdma_state_t state_r;

  logic dp_valid_r;
  logic dp_write_r;
  logic [11:0] dp_addr_r;
  logic rd_pend_r;
  logic [31:0] hrdata_r;

  // Bus slave: writes take no wait state, reads take one so that
  // hrdata comes from a flop and sees a write just before it
  logic addr_take;
  assign addr_take = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_pend_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 12'h000;
      rd_pend_r <= 1'b0;
    end else begin
      if (hready) begin
        dp_valid_r <= addr_take;
        dp_write_r <= hwrite;
        dp_addr_r <= haddr[11:0];
      end
      rd_pend_r <= addr_take & ~hwrite;
    end
  end

  logic wr;
  logic w_cur_ptr [2];
  logic w_cur_cnt [2];
  logic w_nxt_ptr [2];
  logic w_nxt_cnt [2];
  logic w_ctl;
  logic wdata_nz;
  logic rd_tx;
  logic rd_b;
  assign wr = dp_valid_r & dp_write_r;
  assign wdata_nz = hwdata[15:0] != PDMA_CNT_RESET;
  assign w_ctl = wr & (dp_addr_r == PDMA_OFF_CONTROL);
  assign rd_tx = (dp_addr_r == PDMA_OFF_TX_CUR_PTR) | (dp_addr_r == PDMA_OFF_TX_CUR_CNT)
               | (dp_addr_r == PDMA_OFF_TX_NXT_PTR) | (dp_addr_r == PDMA_OFF_TX_NXT_CNT);
  assign rd_b = bank_of(rd_tx, half_duplex);

  // Receive and transmit views land in the same bank in half duplex
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      w_cur_ptr[b] = 1'b0;
      w_cur_cnt[b] = 1'b0;
      w_nxt_ptr[b] = 1'b0;
      w_nxt_cnt[b] = 1'b0;
    end
    if (wr) begin
      unique case (dp_addr_r)
        PDMA_OFF_RX_CUR_PTR, PDMA_OFF_TX_CUR_PTR: w_cur_ptr[rd_b] = 1'b1;
        PDMA_OFF_RX_CUR_CNT, PDMA_OFF_TX_CUR_CNT: w_cur_cnt[rd_b] = 1'b1;
        PDMA_OFF_RX_NXT_PTR, PDMA_OFF_TX_NXT_PTR: w_nxt_ptr[rd_b] = 1'b1;
        PDMA_OFF_RX_NXT_CNT, PDMA_OFF_TX_NXT_CNT: w_nxt_cnt[rd_b] = 1'b1;
        default: ;
      endcase
    end
  end

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (dp_addr_r)
      PDMA_OFF_RX_CUR_PTR, PDMA_OFF_TX_CUR_PTR: rd_val = cur_ptr_r[rd_b];
      PDMA_OFF_RX_CUR_CNT, PDMA_OFF_TX_CUR_CNT: rd_val = {16'h0000, cur_cnt_r[rd_b]};
      PDMA_OFF_RX_NXT_PTR, PDMA_OFF_TX_NXT_PTR: rd_val = nxt_ptr_r[rd_b];
      PDMA_OFF_RX_NXT_CNT, PDMA_OFF_TX_NXT_CNT: rd_val = {16'h0000, nxt_cnt_r[rd_b]};
      PDMA_OFF_STATUS: begin
        rd_val[PDMA_STS_RX] = rx_en_r;
        rd_val[PDMA_STS_TX] = tx_en_r;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_pend_r) begin
      hrdata_r <= dp_valid_r ? rd_val : 32'h0000_0000;
    end
  end

  // Transfer enables; a disable beats an enable in the same write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_en_r <= 1'b0;
      tx_en_r <= 1'b0;
    end else if (w_ctl) begin
      if (hwdata[PDMA_CTL_RX_DIS] | (half_duplex & hwdata[PDMA_CTL_TX_DIS])) begin
        rx_en_r <= 1'b0;
      end else if (hwdata[PDMA_CTL_RX_EN]) begin
        rx_en_r <= 1'b1;
      end
      if (hwdata[PDMA_CTL_TX_DIS] | (half_duplex & hwdata[PDMA_CTL_RX_DIS])) begin
        tx_en_r <= 1'b0;
      end else if (half_duplex & hwdata[PDMA_CTL_RX_EN]) begin
        tx_en_r <= 1'b0;
      end else if (hwdata[PDMA_CTL_TX_EN]) begin
        tx_en_r <= 1'b1;
      end
    end
  end

  // Transfer engine: one element at a time, receive first
  logic rxb;
  logic txb;
  logic rx_go;
  logic tx_go;
  assign rxb = 1'b0;
  assign txb = bank_of(1'b1, half_duplex);
  assign rx_go = rx_pend_r & rx_en_r & (cur_cnt_r[rxb] != PDMA_CNT_RESET);
  assign tx_go = tx_pend_r & tx_en_r & (cur_cnt_r[txb] != PDMA_CNT_RESET);

  logic rx_take;
  logic tx_take;
  assign rx_take = (state_r == PDMA_ST_IDLE) & rx_go;
  assign tx_take = (state_r == PDMA_ST_IDLE) & ~rx_go & tx_go;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_pend_r <= 1'b0;
      tx_pend_r <= 1'b0;
    end else begin
      // A new strobe in the cycle the old one is taken stays pending
      rx_pend_r <= rx_ready | (rx_pend_r & ~rx_take);
      tx_pend_r <= tx_ready | (tx_pend_r & ~tx_take);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= PDMA_ST_IDLE;
      hold_r <= 32'h0000_0000;
    end else begin
      unique case (state_r)
        PDMA_ST_IDLE: begin
          if (rx_take) begin
            hold_r <= receive_holding_reg;
            state_r <= PDMA_ST_RX_MEM;
          end else if (tx_take) begin
            state_r <= PDMA_ST_TX_MEM;
          end
        end
        PDMA_ST_RX_MEM: begin
          if (mem_ack) begin
            state_r <= PDMA_ST_IDLE;
          end
        end
        PDMA_ST_TX_MEM: begin
          if (mem_ack) begin
            hold_r <= mem_rdata;
            state_r <= PDMA_ST_TX_HOLD;
          end
        end
        PDMA_ST_TX_HOLD: state_r <= PDMA_ST_IDLE;
      endcase
    end
  end

  logic act_b;
  assign act_b = (state_r == PDMA_ST_RX_MEM) ? rxb : txb;
  assign rx_holding_read = rx_take;
  assign mem_req = (state_r == PDMA_ST_RX_MEM) | (state_r == PDMA_ST_TX_MEM);
  assign mem_write = state_r == PDMA_ST_RX_MEM;
  assign mem_addr = cur_ptr_r[act_b];
  assign mem_size = elem_size;
  assign mem_wdata = hold_r;
  assign transmit_holding_reg = hold_r;
  assign tx_holding_write = state_r == PDMA_ST_TX_HOLD;

  // An element is done once it reaches memory or the holding register
  logic adv;
  logic last;
  logic reload;
  logic rx_done;
  logic tx_done;
  assign rx_done = (state_r == PDMA_ST_RX_MEM) & mem_ack;
  assign tx_done = state_r == PDMA_ST_TX_HOLD;
  assign adv = rx_done | tx_done;
  assign last = cur_cnt_r[act_b] == 16'h0001;
  assign reload = last & (nxt_cnt_r[act_b] != PDMA_CNT_RESET);

  // Bus writes come last so software always wins a same-cycle update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int b = 0; b < 2; b++) begin
        cur_ptr_r[b] <= PDMA_PTR_RESET;
        cur_cnt_r[b] <= PDMA_CNT_RESET;
        nxt_ptr_r[b] <= PDMA_PTR_RESET;
        nxt_cnt_r[b] <= PDMA_CNT_RESET;
      end
    end else begin
      if (adv) begin
        if (reload) begin
          cur_ptr_r[act_b] <= nxt_ptr_r[act_b];
          cur_cnt_r[act_b] <= nxt_cnt_r[act_b];
          nxt_ptr_r[act_b] <= PDMA_PTR_RESET;
          nxt_cnt_r[act_b] <= PDMA_CNT_RESET;
        end else begin
          cur_ptr_r[act_b] <= cur_ptr_r[act_b] + elem_incr(elem_size);
          cur_cnt_r[act_b] <= cur_cnt_r[act_b] - 16'h0001;
        end
      end
      for (int b = 0; b < 2; b++) begin
        if (w_cur_ptr[b]) cur_ptr_r[b] <= hwdata;
        if (w_cur_cnt[b]) cur_cnt_r[b] <= hwdata[15:0];
        if (w_nxt_ptr[b]) nxt_ptr_r[b] <= hwdata;
        if (w_nxt_cnt[b]) nxt_cnt_r[b] <= hwdata[15:0];
      end
    end
  end

  // Completion flags go to the peripheral's status register only
  logic rx_end_set;
  logic rx_full_set;
  logic tx_end_set;
  logic tx_empty_set;
  logic rx_clr;
  logic tx_clr;
  assign rx_end_set = rx_done & last;
  assign rx_full_set = rx_end_set & ~reload;
  assign tx_end_set = tx_done & last;
  assign tx_empty_set = tx_end_set & ~reload;
  assign rx_clr = wdata_nz & (w_cur_cnt[rxb] | w_nxt_cnt[rxb]);
  assign tx_clr = wdata_nz & (w_cur_cnt[txb] | w_nxt_cnt[txb]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_end_flag <= 1'b0;
      rx_buffer_full_flag <= 1'b0;
      tx_end_flag <= 1'b0;
      tx_buffer_empty_flag <= 1'b0;
    end else begin
      rx_end_flag <= rx_end_set | (rx_end_flag & ~rx_clr);
      rx_buffer_full_flag <= rx_full_set | (rx_buffer_full_flag & ~rx_clr);
      tx_end_flag <= tx_end_set | (tx_end_flag & ~tx_clr);
      tx_buffer_empty_flag <= tx_empty_set | (tx_buffer_empty_flag & ~tx_clr);
    end
  end

  sequence s_rx_take;
    rx_holding_read;
  endsequence

  sequence s_rx_store;
    mem_req && mem_write;
  endsequence

  property p_rx_flow;
    @(posedge hclk) disable iff (!hresetn)
      s_rx_take |=> s_rx_store;
  endproperty
  a_rx_flow: assert property (p_rx_flow) else $error("rx take not followed by store");

  property p_tx_flow;
    @(posedge hclk) disable iff (!hresetn)
      (state_r == PDMA_ST_TX_MEM && mem_ack) |=>
        tx_holding_write && transmit_holding_reg == $past(mem_rdata);
  endproperty
  a_tx_flow: assert property (p_tx_flow) else $error("fetched data not written out");

  // Bank 0 checked directly; mem_addr switches bank once the engine idles
  property p_incr;
    @(posedge hclk) disable iff (!hresetn)
      (rx_done && !reload && !wr) |=>
        cur_ptr_r[0] == $past(cur_ptr_r[0]) + elem_incr($past(elem_size));
  endproperty
  a_incr: assert property (p_incr) else $error("pointer advance wrong");
  property p_decr;
    @(posedge hclk) disable iff (!hresetn)
      (rx_done && !reload && !wr) |=> cur_cnt_r[0] == $past(cur_cnt_r[0]) - 16'h0001;
  endproperty
  a_decr: assert property (p_decr) else $error("counter not decremented");
  property p_reload;
    @(posedge hclk) disable iff (!hresetn)
      (rx_done && reload && !wr) |=>
        cur_cnt_r[0] == $past(nxt_cnt_r[0]) && nxt_cnt_r[0] == PDMA_CNT_RESET;
  endproperty
  a_reload: assert property (p_reload) else $error("reload wrong");
  property p_halt;
    @(posedge hclk) disable iff (!hresetn)
      (cur_cnt_r[rxb] == PDMA_CNT_RESET || !rx_en_r) |-> !rx_holding_read;
  endproperty
  a_halt: assert property (p_halt) else $error("transfer with zero count");
  property p_rx_full;
    @(posedge hclk) disable iff (!hresetn)
      rx_full_set |=> rx_buffer_full_flag && rx_end_flag;
  endproperty
  a_rx_full: assert property (p_rx_full) else $error("rx flags not set");
  property p_tx_empty;
    @(posedge hclk) disable iff (!hresetn)
      tx_empty_set |=> tx_buffer_empty_flag && tx_end_flag;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx flags not set");
  property p_ctl;
    @(posedge hclk) disable iff (!hresetn)
      (w_ctl && hwdata[PDMA_CTL_RX_EN] && hwdata[PDMA_CTL_RX_DIS]) |=> !rx_en_r;
  endproperty
  a_ctl: assert property (p_ctl) else $error("disable did not win");
  property p_hd_excl;
    @(posedge hclk) disable iff (!hresetn)
      (w_ctl && half_duplex && hwdata[PDMA_CTL_RX_EN]) |=> !tx_en_r;
  endproperty
  a_hd_excl: assert property (p_hd_excl) else $error("half duplex both enabled");

endmodule
`default_nettype wire

// ==== sim/pdma_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pdma_mem_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:63];
  logic [3:0] cnt;
  logic done;
  // mem_ack comes lat+1 cycles after mem_req rises, one ack per request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      done <= 1'b0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      // Idle data toggles so a stale word never looks valid
      mem_rdata <= ~mem_rdata;
      if (!mem_req) begin
        cnt <= 4'h0;
        done <= 1'b0;
      end else if (!done && cnt >= lat) begin
        mem_ack <= 1'b1;
        done <= 1'b1;
        if (mem_write) begin
          mem[mem_addr[7:2]] <= mem_wdata;
        end else begin
          mem_rdata <= mem[mem_addr[7:2]];
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
  import pdma_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic half_duplex = 1'b0;
  logic [1:0] elem_size = PDMA_SZ_WORD;
  logic rx_ready = 1'b0;
  logic tx_ready = 1'b0;
  logic [31:0] rx_data = 32'h0;
  logic [3:0] lat = 4'h0;
  logic [31:0] q, rv, d0, tx_seen;
  wire logic hreadyout, hresp, rx_holding_read, tx_holding_write, mem_req, mem_write, mem_ack;
  wire logic rx_end_flag, rx_buffer_full_flag, tx_end_flag, tx_buffer_empty_flag;
  wire logic [31:0] hrdata, tx_data, mem_addr, mem_wdata, mem_rdata;
  wire logic [1:0] mem_size;
  int num_errors = 0;
  int checks_done = 0;
  int n_rd = 0;
  int seed = 3124;

  always #2 hclk = ~hclk;

  pdma_channel uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .half_duplex, .elem_size, .rx_ready, .tx_ready, .receive_holding_reg(rx_data),
    .rx_holding_read, .transmit_holding_reg(tx_data), .tx_holding_write, .mem_req,
    .mem_write, .mem_addr, .mem_size, .mem_wdata, .mem_ack, .mem_rdata, .rx_end_flag,
    .rx_buffer_full_flag, .tx_end_flag, .tx_buffer_empty_flag);

  pdma_mem_model mem_i (.hclk, .hresetn, .mem_req, .mem_write, .mem_addr,
    .mem_wdata, .lat, .mem_ack, .mem_rdata);

  always @(posedge hclk) begin
    if (rx_holding_read === 1'b1) n_rd++;
    if (tx_holding_write === 1'b1) tx_seen <= tx_data;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Bounded wait for hreadyout or, with ack set, the memory answer
  task automatic edge_wait(input bit ack);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((ack ? mem_ack : hreadyout) !== 1'b1 && n < 60);
    if ((ack ? mem_ack : hreadyout) !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic xfer(input bit w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    edge_wait(1'b0);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    edge_wait(1'b0);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic step(input logic hd, input logic [31:0] w, input logic [31:0] e);
    half_duplex <= hd;
    wr(PDMA_OFF_CONTROL, w);
    rd(PDMA_OFF_STATUS, e);
  endtask

  // One ready strobe; wt waits for the element to land
  task automatic pulse(input bit tx, input bit wt);
    lat <= 4'($random(seed));
    if (tx) tx_ready <= 1'b1;
    else begin
      rx_ready <= 1'b1;
      rx_data <= $random(seed);
    end
    @(posedge hclk);
    rx_ready <= 1'b0;
    tx_ready <= 1'b0;
    if (wt) begin
      edge_wait(1'b1);
      repeat (3) @(posedge hclk);
    end
  endtask

  function automatic logic [31:0] inc(input logic [1:0] s);
    return s == PDMA_SZ_HALF ? 32'h2 : (s == PDMA_SZ_WORD ? 32'h4 : 32'h1);
  endfunction

  function automatic logic [31:0] cmask(input logic [11:0] a, input logic [31:0] d);
    return a[2] ? {16'h0, d[15:0]} : d;
  endfunction

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (logic [11:0] a = 12'h100; a <= 12'h128; a += 12'h4) rd(a, 32'h0);
    chk1(hresp, 1'b0);
    $display("done: reset values");
    for (logic [11:0] a = 12'h100; a <= 12'h11C; a += 12'h4) begin
      rv = $random(seed);
      wr(a, rv);
      rd(a, cmask(a, rv));
    end
    $display("done: register access");
    step(1'b0, 32'h101, 32'h101);
    step(1'b0, 32'h0, 32'h101);
    step(1'b0, 32'h3, 32'h100);
    step(1'b0, 32'h200, 32'h0);
    step(1'b1, 32'h100, 32'h100);
    step(1'b1, 32'h1, 32'h1);
    step(1'b1, 32'h2, 32'h0);
    rv = $random(seed);
    wr(PDMA_OFF_RX_CUR_PTR, rv);
    rd(PDMA_OFF_TX_CUR_PTR, rv);
    step(1'b0, 32'h101, 32'h101);
    rd(PDMA_OFF_CONTROL, 32'h0);
    $display("done: control");
    wr(PDMA_OFF_RX_CUR_PTR, 32'h40);
    wr(PDMA_OFF_RX_CUR_CNT, 32'h2);
    wr(PDMA_OFF_RX_NXT_PTR, 32'h80);
    wr(PDMA_OFF_RX_NXT_CNT, 32'h1);
    pulse(1'b0, 1'b1);
    d0 = rx_data;
    chk(mem_i.mem[6'h10], d0);
    rd(PDMA_OFF_RX_CUR_CNT, 32'h1);
    wr(PDMA_OFF_RX_CUR_PTR, 32'h20);
    pulse(1'b0, 1'b1);
    chk(mem_i.mem[6'h08], rx_data);
    chk1(rx_end_flag, 1'b1);
    chk1(rx_buffer_full_flag, 1'b0);
    rd(PDMA_OFF_RX_CUR_PTR, 32'h80);
    rd(PDMA_OFF_RX_CUR_CNT, 32'h1);
    rd(PDMA_OFF_RX_NXT_CNT, 32'h0);
    pulse(1'b0, 1'b1);
    chk(mem_i.mem[6'h20], rx_data);
    chk1(rx_buffer_full_flag, 1'b1);
    wr(PDMA_OFF_RX_CUR_CNT, 32'h7);
    // Flags clear at the edge that ends the write; look once settled
    @(posedge hclk);
    chk1(rx_end_flag, 1'b0);
    chk1(rx_buffer_full_flag, 1'b0);
    $display("done: receive");
    wr(PDMA_OFF_TX_CUR_PTR, 32'h40);
    wr(PDMA_OFF_TX_CUR_CNT, 32'h1);
    wr(PDMA_OFF_TX_NXT_CNT, 32'h0);
    pulse(1'b1, 1'b1);
    chk(tx_seen, d0);
    chk1(tx_end_flag, 1'b1);
    chk1(tx_buffer_empty_flag, 1'b1);
    rd(PDMA_OFF_TX_CUR_PTR, 32'h44);
    wr(PDMA_OFF_TX_CUR_CNT, 32'h1);
    @(posedge hclk);
    chk1(tx_end_flag, 1'b0);
    chk1(tx_buffer_empty_flag, 1'b0);
    $display("done: transmit");
    for (logic [2:0] s = 3'h0; s < 3'h3; s++) begin
      elem_size <= s[1:0];
      wr(PDMA_OFF_RX_CUR_PTR, 32'h0);
      wr(PDMA_OFF_RX_CUR_CNT, 32'h1);
      pulse(1'b0, 1'b1);
      rd(PDMA_OFF_RX_CUR_PTR, inc(s[1:0]));
      rd(PDMA_OFF_RX_CUR_CNT, 32'h0);
      chk({30'h0, mem_size}, {30'h0, s[1:0]});
    end
    $display("done: element sizes");
    rv = 32'(n_rd);
    pulse(1'b0, 1'b0);
    repeat (10) @(posedge hclk);
    chk(32'(n_rd), rv);
    $display("done: zero count halt");
    give_verdict();
  end
endmodule
`default_nettype wire
